/* File: rtl/pbs_pkg.sv */
/*
 * constants shared by the burst sram port and its write buffer.
 * assumes a single 100 MHz clock domain.
 */
package pbs_pkg;
	localparam int ADDR_W     = 17;
	localparam int BYTE_N     = 4;
	localparam int BYTE_W     = 9;
	localparam int DATA_W     = BYTE_N * BYTE_W;
	localparam int BURST_W    = 2;
	localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
	localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;
	localparam logic [BURST_W-1:0] BURST_LAST  = 2'h3;
	localparam logic ORDER_LINEAR     = 1'h0;
	localparam logic ORDER_INTERLEAVE = 1'h1;
	localparam int BUF_DEPTH  = 2;

	typedef enum logic [2:0] {
		PBS_IDLE  = 3'h1,
		PBS_READ  = 3'h2,
		PBS_WRITE = 3'h4
	} pbs_burst_e;
endpackage

/* File: rtl/pbs_sram_port.sv */
/*
 * control and burst pipeline of a pipelined no-turnaround burst sram port.
 * assumes an external storage array: asynchronous read on mem_rd_addr_out,
 * write words handed over with valid/ready through a two-entry buffer.
 */
// How it works
// [R1] burst steps low two address bits from base, linear or interleaved per order input.
// [R2] a load (load_or_advance_n low) ends any burst in progress.
// [R3] direction is fixed at load; read/write input ignored while advancing.
// [R4] a write starts only with read/write low on a load edge.
// [R5] controller gives valid byte enables on every write and burst-write cycle.
// [R6] byte enables from the address cycle pair with data two cycles later.
// [R7] clock enable high makes the edge do nothing in the port, but the write buffer still drains toward the array.
// [R8] on a suppressed edge all pipeline, counter and output registers hold.
// [R9] any inactive chip select starts a deselect and no new access.
// [R10] data bus released two cycles after deselect, pending transfers first.
// [R11] pending reads still delivered and pending writes still captured when deselected.
// [R12] selected only with both active-low selects low and high select high.
// [R13] counter advances each continue cycle and wraps after the fourth.
// [R14] on a suppressed edge output keeps read data or stays released.
// [R15] outputs disable themselves on writes; output enable may stay active.
// [R16] dummy read or aborted write still sets up access and advances counter.
// [R17] read data and write capture occur two accepted edges after the address.
`timescale 1ns/1ps
module pbs_sram_port
	import pbs_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W,
	parameter int BN = BYTE_N
) (
	// clock and reset
	input  wire logic          clk_in,
	input  wire logic          nrst_in,
	// bus control
	input  wire logic          clk_en_n_in,
	input  wire logic          chip_sel_a_n_in,
	input  wire logic          chip_sel_b_n_in,
	input  wire logic          chip_sel_c_hi_in,
	input  wire logic          load_or_advance_n_in,
	input  wire logic          rd_wr_n_in,
	input  wire logic [BN-1:0] byte_write_en_n_in,
	input  wire logic [AW-1:0] addr_in,
	input  wire logic          burst_order_in,
	input  wire logic          out_en_n_in,
	input  wire logic          sleep_request_in,
	// data pins
	input  wire logic [DW-1:0] dq_in,
	output logic      [DW-1:0] dq_out,
	output logic               dq_oe_out,
	// storage array
	output logic      [AW-1:0] mem_rd_addr_out,
	input  wire logic [DW-1:0] mem_rdata_in,
	output logic               mem_wr_valid_out,
	input  wire logic          mem_wr_ready_in,
	output logic      [AW-1:0] mem_wr_addr_out,
	output logic      [BN-1:0] mem_wr_be_out,
	output logic      [DW-1:0] mem_wr_data_out,
	// status
	output logic               wr_buf_full_out
);
	localparam int WW = AW + BN + DW;

	////////////////////////////////////////////////////////////////////////////
	// state
	pbs_burst_e           mode_q;
	logic [AW-1:0]        base_q;
	logic [BURST_W-1:0]   cnt_q;
	logic                 s1_vld_q, s1_wr_q, s2_vld_q, s2_wr_q;
	logic [AW-1:0]        s1_addr_q, s2_addr_q;
	logic [BN-1:0]        s1_be_q, s2_be_q;
	logic [DW-1:0]        s2_rdata_q, dq_q;
	logic                 oe_q;
	logic                 buf_ready;
	logic                 buf_vld;
	logic [WW-1:0]        buf_out;

	////////////////////////////////////////////////////////////////////////////
	// decode
	wire                 accept   = ~clk_en_n_in & buf_ready; // [R7]
	wire                 selected = ~chip_sel_a_n_in & ~chip_sel_b_n_in & chip_sel_c_hi_in // [R12]
	                                & ~sleep_request_in;
	wire                 is_load  = ~load_or_advance_n_in; // [R2]
	wire                 bursting = (mode_q != PBS_IDLE);
	wire                 go_load  = is_load & selected;
	wire                 go_cont  = ~is_load & selected & bursting;
	wire [BURST_W-1:0]   cnt_nx   = go_load ? BURST_FIRST : cnt_q + BURST_STEP; // [R13]
	wire [BURST_W-1:0]   base_lo  = base_q[BURST_W-1:0];
	wire [BURST_W-1:0]   lo_bits  = (burst_order_in == ORDER_INTERLEAVE) ? (base_lo ^ cnt_nx) // [R1]
	                                                                       : (base_lo + cnt_nx);
	wire [AW-1:0]        cont_adr = {base_q[AW-1:BURST_W], lo_bits};
	wire                 new_wr   = go_load ? ~rd_wr_n_in : (mode_q == PBS_WRITE); // [R3] [R4]
	wire                 push     = accept & s2_vld_q & s2_wr_q & ~(&s2_be_q); // [R6] [R11]
	wire [WW-1:0]        buf_in   = {s2_addr_q, ~s2_be_q, dq_in};
	pbs_burst_e          mode_nx;

	always_comb begin
		mode_nx = mode_q;
		if (!selected) begin
			mode_nx = PBS_IDLE; // [R9]
		end else if (is_load) begin
			mode_nx = rd_wr_n_in ? PBS_READ : PBS_WRITE; // [R3]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// burst state and counter
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			mode_q <= PBS_IDLE;
			base_q <= '0;
			cnt_q  <= BURST_FIRST;
		end else if (accept) begin // [R8]
			case (mode_nx)
				PBS_IDLE:  mode_q <= PBS_IDLE;
				PBS_READ:  mode_q <= PBS_READ;
				PBS_WRITE: mode_q <= PBS_WRITE;
				default:   mode_q <= PBS_IDLE;
			endcase
			if (go_load) begin
				base_q <= addr_in; // [R2]
			end
			if (go_load || go_cont) begin
				cnt_q <= cnt_nx; // [R13] [R16]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// two-stage pipeline
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			s1_vld_q <= 1'b0;
			s1_wr_q  <= 1'b0;
			s1_addr_q <= '0;
			s1_be_q  <= '1;
			s2_vld_q <= 1'b0;
			s2_wr_q  <= 1'b0;
			s2_addr_q <= '0;
			s2_be_q  <= '1;
			s2_rdata_q <= '0;
		end else if (accept) begin // [R8]
			s1_vld_q  <= go_load | go_cont; // [R9] [R16]
			s1_wr_q   <= new_wr;
			s1_addr_q <= go_load ? addr_in : cont_adr; // [R1]
			s1_be_q   <= byte_write_en_n_in; // [R5] [R6]
			s2_vld_q  <= s1_vld_q; // [R11]
			s2_wr_q   <= s1_wr_q;
			s2_addr_q <= s1_addr_q;
			s2_be_q   <= s1_be_q;
			s2_rdata_q <= mem_rdata_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output register
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			dq_q <= '0;
			oe_q <= 1'b0;
		end else if (accept) begin // [R14]
			dq_q <= s2_rdata_q; // [R17]
			oe_q <= s2_vld_q & ~s2_wr_q & ~out_en_n_in; // [R10] [R15] [R16]
		end
	end

	assign dq_out          = dq_q;
	assign dq_oe_out       = oe_q;
	assign mem_rd_addr_out = s1_addr_q;

	////////////////////////////////////////////////////////////////////////////
	// write buffer toward the array
	pbs_wr_buf #(
		.WIDTH         (WW)
	) u_wbuf (
		.clk_in        (clk_in),
		.nrst_in       (nrst_in),
		.in_valid_in   (push),
		.in_ready_out  (buf_ready),
		.in_data_in    (buf_in),
		.out_valid_out (buf_vld),
		.out_ready_in  (mem_wr_ready_in),
		.out_data_out  (buf_out)
	);

	assign mem_wr_valid_out = buf_vld;
	assign {mem_wr_addr_out, mem_wr_be_out, mem_wr_data_out} = buf_out;
	assign wr_buf_full_out  = ~buf_ready;

	////////////////////////////////////////////////////////////////////////////
	// checks
	burst_wrap_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R13]
		accept && go_cont && cnt_q == BURST_LAST |=> cnt_q == BURST_FIRST)
		else $error("burst counter did not wrap");

	load_restart_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R2]
		accept && go_load |=> cnt_q == BURST_FIRST && s1_addr_q == $past(addr_in))
		else $error("load did not restart burst");

	stall_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R8]
		clk_en_n_in |=> $stable(cnt_q) && $stable(s1_vld_q) && $stable(s2_vld_q))
		else $error("state moved on a suppressed edge");

	stall_output_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R14]
		clk_en_n_in |=> $stable(dq_out) && $stable(dq_oe_out))
		else $error("output changed on a suppressed edge");

	deselect_idle_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R9]
		accept && (chip_sel_a_n_in || chip_sel_b_n_in || !chip_sel_c_hi_in) |=> !s1_vld_q)
		else $error("access started while deselected");

	dir_fixed_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R3]
		accept && go_cont |=> s1_wr_q == ($past(mode_q) == PBS_WRITE))
		else $error("burst direction changed");

	read_latency_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R17]
		accept && go_load && rd_wr_n_in ##1 accept ##1 accept && !out_en_n_in |=> dq_oe_out)
		else $error("read data not driven two edges after address");

	write_quiet_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R15]
		accept && go_load && !rd_wr_n_in ##1 accept ##1 accept |=> !dq_oe_out)
		else $error("bus driven during write");

	release_two_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R10]
		accept && !selected ##1 accept && !selected ##1 accept |=> !dq_oe_out)
		else $error("bus not released after deselect");

	write_pair_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R6]
		accept && go_load && !rd_wr_n_in && !(&byte_write_en_n_in) ##1 accept ##1 accept |-> push)
		else $error("write data not captured with its byte enables");
endmodule

/* File: rtl/pbs_wr_buf.sv */
/*
 * two-entry write buffer with valid/ready on both sides.
 * assumes synchronous active-low reset and one clock.
 */
`timescale 1ns/1ps
module pbs_wr_buf
	import pbs_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             nrst_in,
	// filling side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// draining side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	// entry 0 is the head, entry 1 the spare
	logic [WIDTH-1:0] ent_q [BUF_DEPTH];
	logic             vld_q [BUF_DEPTH];
	wire              push    = in_valid_in & ~vld_q[1];
	wire              head_go = ~vld_q[0] | out_ready_in;

	assign in_ready_out  = ~vld_q[1];
	assign out_valid_out = vld_q[0];
	assign out_data_out  = ent_q[0];

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			vld_q[0] <= 1'b0;
			vld_q[1] <= 1'b0;
			ent_q[0] <= '0;
			ent_q[1] <= '0;
		end else if (head_go) begin
			vld_q[0] <= vld_q[1] | push;
			ent_q[0] <= vld_q[1] ? ent_q[1] : in_data_in;
			vld_q[1] <= 1'b0;
		end else if (push) begin
			vld_q[1] <= 1'b1;
			ent_q[1] <= in_data_in;
		end
	end

	no_overrun_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R11]
		vld_q[1] && !out_ready_in |=> vld_q[1] && $stable(ent_q[1]))
		else $error("write buffer spare entry lost");
endmodule

/* File: test/pbs_mem_model.sv */
/*
 * storage array model: asynchronous read, valid/ready write with byte enables.
 * assumes one clock; stall_in holds ready low to back up the write buffer.
 */
`timescale 1ns/1ps
module pbs_mem_model
	import pbs_pkg::*;
(
	// clock and stall
	input  wire logic              clk_in,
	input  wire logic              stall_in,
	// array side
	input  wire logic [ADDR_W-1:0] rd_addr_in,
	output logic      [DATA_W-1:0] rdata_out,
	input  wire logic              wr_valid_in,
	output logic                   wr_ready_out,
	input  wire logic [ADDR_W-1:0] wr_addr_in,
	input  wire logic [BYTE_N-1:0] wr_be_in,
	input  wire logic [DATA_W-1:0] wr_data_in
);
	logic [DATA_W-1:0] mem [256];
	initial for (int i = 0; i < 256; i++) mem[i] = {BYTE_N{1'b0, 8'(i)}};
	assign rdata_out    = mem[rd_addr_in[7:0]];
	assign wr_ready_out = !stall_in;
	always @(posedge clk_in)
		if (wr_valid_in && wr_ready_out)
			for (int b = 0; b < BYTE_N; b++)
				if (wr_be_in[b]) mem[wr_addr_in[7:0]][b*BYTE_W+:BYTE_W] <= wr_data_in[b*BYTE_W+:BYTE_W];
endmodule

/* File: test/testbench.sv */
/*
 * self-checking bench for the burst sram port.
 * assumes the port's default parameters and the array model beside it.
 */
`timescale 1ns/1ps
module testbench
	import pbs_pkg::*;
;
	logic              clk = 0, nrst = 0, stall = 0, ord = 0, ord_nx = 0;
	logic              ld_n = 1, rw = 1, oen = 0, cke_n = 0;
	logic [3:0]        sel = 4'h0;
	logic [BYTE_N-1:0] ben = 4'hf, wbe;
	logic [ADDR_W-1:0] addr = 17'h0, ra, wa;
	logic [DATA_W-1:0] dq = 36'h0, dq_o, rdat, wd, ref_m [256];
	logic              oe, wv, wrdy, full, prev_en = 0;
	logic [DATA_W:0]   q [$], last = 37'h0;
	int                err_total = 0, comparisons = 0;
	////////////////////////////////////////////////////////////////
	pbs_sram_port pbs_sram_port_i (.clk_in(clk), .nrst_in(nrst), .clk_en_n_in(cke_n),
		.chip_sel_a_n_in(sel[3]), .chip_sel_b_n_in(sel[2]), .chip_sel_c_hi_in(!sel[1]),
		.load_or_advance_n_in(ld_n), .rd_wr_n_in(rw), .byte_write_en_n_in(ben), .addr_in(addr),
		.burst_order_in(ord), .out_en_n_in(oen), .sleep_request_in(sel[0]), .dq_in(dq),
		.dq_out(dq_o), .dq_oe_out(oe), .mem_rd_addr_out(ra), .mem_rdata_in(rdat),
		.mem_wr_valid_out(wv), .mem_wr_ready_in(wrdy), .mem_wr_addr_out(wa),
		.mem_wr_be_out(wbe), .mem_wr_data_out(wd), .wr_buf_full_out(full));
	pbs_mem_model pbs_mem_model_i (.clk_in(clk), .stall_in(stall), .rd_addr_in(ra),
		.rdata_out(rdat), .wr_valid_in(wv), .wr_ready_out(wrdy), .wr_addr_in(wa),
		.wr_be_in(wbe), .wr_data_in(wd));
	initial forever #5 clk = !clk;
	initial begin
		#20000;
		err_total++;
		stop_test();
	end
	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [DATA_W:0] g, e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	function automatic logic [DATA_W:0] rx(input logic [ADDR_W-1:0] a);
		return {1'b1, ref_m[a[7:0]]};
	endfunction
	function automatic logic [DATA_W-1:0] mrg(input logic [DATA_W-1:0] o, n, logic [BYTE_N-1:0] b);
		for (int i = 0; i < BYTE_N; i++)
			if (!b[i]) o[i*BYTE_W+:BYTE_W] = n[i*BYTE_W+:BYTE_W];
		return o;
	endfunction
	// one bus cycle; x is what this address shows two accepted edges on
	task automatic cyc(input logic l, w, logic [ADDR_W-1:0] a, logic [BYTE_N-1:0] b,
		logic [DATA_W-1:0] d, logic o, logic [3:0] s, logic e, logic [DATA_W:0] x);
		@(posedge clk);
		{ld_n, rw, addr, ben, dq, oen, sel, cke_n, ord} <= {l, w, a, b, d, o, s, !e, ord_nx};
		@(negedge clk);
		if (!prev_en) chk({oe, dq_o}, last);
		else if (q.size() == 3) chk({oe, oe ? dq_o : 36'h0}, q.pop_front());
		if (e) q.push_back(x);
		last = {oe, dq_o};
		prev_en = e;
	endtask
	////////////////////////////////////////////////////////////////
	// deselected idle cycles until every queued answer has been judged
	task automatic flush();
		repeat (3) cyc(1, 1, 0, 4'hf, 0, 0, 4'h8, 1, 0);
	endtask
	task automatic t_burst();
		logic [1:0] n;
		for (int o = 0; o < 2; o++) begin
			ord_nx = o[0];
			for (int i = 0; i < 6; i++) begin
				n = o ? 2'h1 ^ i[1:0] : 2'h1 + i[1:0];
				cyc(i != 0, i == 0, i ? 17'h1ffff : 17'h105, 4'hf, 0, 0, 0, 1, rx({15'h41, n}));
			end
			cyc(0, 1, 17'h10a, 4'hf, 0, 0, 0, 1, rx(17'h10a));
			cyc(1, 1, 0, 4'hf, 0, 0, 0, 1, rx(17'h10b));
		end
		flush();
	endtask
	task automatic t_write();
		ref_m[8'h20] = mrg(ref_m[8'h20], 36'h123456789, 4'he);
		ref_m[8'h21] = 36'hfedcba987;
		ref_m[8'h23] = mrg(ref_m[8'h23], 36'h0f0f0f0f0, 4'h7);
		cyc(0, 0, 17'h20, 4'he, 0, 0, 0, 1, 0);
		cyc(1, 1, 0, 4'h0, 0, 0, 0, 1, 0);
		cyc(1, 1, 0, 4'hf, 36'h123456789, 0, 0, 1, 0);
		cyc(1, 1, 0, 4'h7, 36'hfedcba987, 0, 0, 1, 0);
		cyc(0, 1, 17'h22, 4'hf, 36'h5a5a5a5a5, 0, 0, 1, rx(17'h22));
		cyc(0, 1, 17'h21, 4'hf, 36'h0f0f0f0f0, 0, 0, 1, rx(17'h21));
		cyc(0, 1, 17'h20, 4'hf, 0, 0, 0, 1, 0);
		cyc(0, 1, 17'h23, 4'hf, 0, 0, 0, 1, rx(17'h23));
		cyc(1, 1, 0, 4'hf, 0, 1, 4'h8, 1, 0);
		cyc(0, 1, 17'h20, 4'hf, 0, 0, 0, 1, rx(17'h20));
		flush();
	endtask
	task automatic t_desel();
		for (int i = 0; i < 4; i++) begin
			cyc(0, 1, 17'h40 + 17'(i), 4'hf, 0, 0, 0, 1, rx(17'h40 + 17'(i)));
			cyc(0, 1, 17'h48, 4'hf, 0, 0, 4'(4'h1 << i), 1, 0);
			cyc(1, 1, 0, 4'hf, 0, 0, 0, 1, 0);
		end
		flush();
	endtask
	task automatic t_hold();
		cyc(0, 1, 17'h50, 4'hf, 0, 0, 0, 1, rx(17'h50));
		cyc(0, 0, 17'h77, 4'h0, 0, 0, 0, 0, 0);
		cyc(0, 1, 17'h51, 4'hf, 0, 0, 0, 1, rx(17'h51));
		repeat (2) cyc(1, 1, 0, 4'hf, 0, 0, 0, 0, 0);
		cyc(0, 1, 17'h52, 4'hf, 0, 0, 4'h8, 1, 0);
		cyc(1, 1, 0, 4'hf, 0, 0, 0, 0, 0);
		repeat (2) cyc(0, 1, 17'h52, 4'hf, 0, 0, 4'h8, 1, 0);
		flush();
	endtask
	task automatic t_buf();
		stall <= 1;
		cyc(0, 0, 17'h60, 4'h0, 0, 0, 0, 1, 0);
		cyc(1, 0, 0, 4'h0, 0, 0, 0, 1, 0);
		cyc(0, 1, 0, 4'hf, 36'h111111111, 0, 4'h8, 1, 0);
		cyc(0, 1, 0, 4'hf, 36'h222222222, 0, 4'h8, 1, 0);
		repeat (4) @(negedge clk);
		chk({full, 15'h0, wbe, wa}, {1'b1, 15'h0, 4'hf, 17'h60});
		chk({wv, wd}, {1'b1, 36'h111111111});
		stall <= 0;
		repeat (4) @(negedge clk);
		chk({35'h0, full, wv}, 37'h0);
		ref_m[8'h60] = 36'h111111111;
		ref_m[8'h61] = 36'h222222222;
		cyc(0, 1, 17'h60, 4'hf, 0, 0, 0, 1, rx(17'h60));
		cyc(0, 1, 17'h61, 4'hf, 0, 0, 0, 1, rx(17'h61));
		flush();
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 256; i++)
			ref_m[i] = {BYTE_N{1'b0, 8'(i)}};
		repeat (8) @(posedge clk);
		nrst <= 1;
		t_burst();
		t_write();
		t_desel();
		t_hold();
		t_buf();
		stop_test();
	end
endmodule
